//--- src/sirq_regs.v
// Purpose: interrupt enable, wake flag, wake enable and status registers of a spi port
// Assumes: plain register port, read data one cycle after the read strobe
// Notes:   event conditions arrive as one-cycle pulses from the serial engine
//
// Strobed register access was chosen for this implementation.
`timescale 1ns/10ps
`include "sirq_map.vh"

module sirq_regs (
   input  wire        sys_clk,
   input  wire        reset,
   input  wire [7:0]  reg_addr,
   input  wire [31:0] reg_wdata,
   input  wire        reg_wr,
   input  wire        reg_rd,
   output wire [31:0] reg_rdata,
   input  wire        ev_rx_und,
   input  wire        ev_rx_ovr,
   input  wire        ev_tx_und,
   input  wire        ev_tx_ovr,
   input  wire        ev_m_done,
   input  wire        ev_abort,
   input  wire        ev_fault,
   input  wire        ev_rx_full,
   input  wire        ev_rx_level,
   input  wire        ev_tx_empty,
   input  wire        ev_tx_level,
   input  wire        tx_start,
   input  wire        last_char_done,
   input  wire        ss_n,
   output wire        irq,
   output wire        wake_req,
   output wire        busy
);

   // ------------------------------------------------------------
   // storage
   // ------------------------------------------------------------
   reg  [31:0] int_en_q;
   reg  [31:0] wake_en_q;
   reg         master_q;
   reg  [31:0] rdata_q;
   reg  [31:0] rdata_d;
   reg         irq_q;
   reg         wake_q;
   reg         busy_q;
   reg  [31:0] ev_set;
   reg  [31:0] wk_set;
   wire [31:0] int_fl;
   wire [31:0] wake_fl;
   wire        busy_w;
   wire        ss_fall;
   wire        ss_rise;

   wire wr_int_en  = reg_wr && (reg_addr == `SIRQ_OFS_INT_EN);
   wire wr_int_fl  = reg_wr && (reg_addr == `SIRQ_OFS_INT_FL);
   wire wr_wake_fl = reg_wr && (reg_addr == `SIRQ_OFS_WAKE_FL);
   wire wr_wake_en = reg_wr && (reg_addr == `SIRQ_OFS_WAKE_EN);
   wire wr_mode    = reg_wr && (reg_addr == `SIRQ_OFS_MODE);

   // ------------------------------------------------------------
   // activity tracking
   // ------------------------------------------------------------
   sirq_activity u_act (
      .sys_clk        (sys_clk),
      .reset          (reset),
      .master_mode    (master_q),
      .tx_start       (tx_start),
      .last_char_done (last_char_done),
      .ss_n           (ss_n),
      .busy           (busy_w),
      .ss_fall        (ss_fall),
      .ss_rise        (ss_rise)
   );

   // ------------------------------------------------------------
   // event set vectors
   // ------------------------------------------------------------
   always @* begin
      ev_set = 32'h0000_0000;
      ev_set[`SIRQ_B_RX_UND]   = ev_rx_und;
      ev_set[`SIRQ_B_RX_OVR]   = ev_rx_ovr;
      ev_set[`SIRQ_B_TX_UND]   = ev_tx_und;
      ev_set[`SIRQ_B_TX_OVR]   = ev_tx_ovr;
      ev_set[`SIRQ_B_M_DONE]   = ev_m_done & master_q;
      ev_set[`SIRQ_B_ABORT]    = ev_abort & ~master_q;
      ev_set[`SIRQ_B_FAULT]    = ev_fault;
      ev_set[`SIRQ_B_SSD]      = ss_rise & ~master_q;
      ev_set[`SIRQ_B_SSA]      = ss_fall & ~master_q;
      ev_set[`SIRQ_B_RX_FULL]  = ev_rx_full;
      ev_set[`SIRQ_B_RX_LEVEL] = ev_rx_level;
      ev_set[`SIRQ_B_TX_EMPTY] = ev_tx_empty;
      ev_set[`SIRQ_B_TX_LEVEL] = ev_tx_level;
      // wake sources share the low four fifo conditions
      wk_set = 32'h0000_0000;
      wk_set[`SIRQ_B_RX_FULL]  = ev_rx_full;
      wk_set[`SIRQ_B_RX_LEVEL] = ev_rx_level;
      wk_set[`SIRQ_B_TX_EMPTY] = ev_tx_empty;
      wk_set[`SIRQ_B_TX_LEVEL] = ev_tx_level;
   end

   // ------------------------------------------------------------
   // sticky flag banks
   // ------------------------------------------------------------
   sirq_w1c_bank #(
      .MASK (`SIRQ_EVT_MASK)
   ) u_int_fl (
      .sys_clk  (sys_clk),
      .reset    (reset),
      .set_in   (ev_set),
      .clr_wr   (wr_int_fl),
      .clr_data (reg_wdata),
      .flags    (int_fl)
   );

   sirq_w1c_bank #(
      .MASK (`SIRQ_WAKE_MASK)
   ) u_wake_fl (
      .sys_clk  (sys_clk),
      .reset    (reset),
      .set_in   (wk_set),
      .clr_wr   (wr_wake_fl),
      .clr_data (reg_wdata),
      .flags    (wake_fl)
   );

   // ------------------------------------------------------------
   // writable control registers
   // ------------------------------------------------------------
   always @(posedge sys_clk) begin
      if (reset) begin
         int_en_q  <= `SIRQ_RST_INT_EN;
         wake_en_q <= `SIRQ_RST_WAKE;
         master_q  <= 1'b0;
      end else begin
         if (wr_int_en) begin
            // bits 15..12, 11, 9, 8, 5..0 stored; rest held at 0
            int_en_q <= reg_wdata & `SIRQ_EVT_MASK;
         end
         if (wr_wake_en) begin
            wake_en_q <= reg_wdata & `SIRQ_WAKE_MASK;
         end
         if (wr_mode) begin
            master_q <= reg_wdata[`SIRQ_B_MASTER];
         end
      end
   end

   // ------------------------------------------------------------
   // read mux, unmapped reads as zero
   // ------------------------------------------------------------
   always @* begin
      case (reg_addr)
         `SIRQ_OFS_INT_FL:  rdata_d = int_fl;
         `SIRQ_OFS_INT_EN:  rdata_d = int_en_q;
         `SIRQ_OFS_WAKE_FL: rdata_d = wake_fl;
         `SIRQ_OFS_WAKE_EN: rdata_d = wake_en_q;
         `SIRQ_OFS_STAT:    rdata_d = {31'h0000_0000, busy_w};
         `SIRQ_OFS_MODE:    rdata_d = {31'h0000_0000, master_q};
         default:           rdata_d = 32'h0000_0000;
      endcase
   end

   // ------------------------------------------------------------
   // registered outputs
   // ------------------------------------------------------------
   always @(posedge sys_clk) begin
      if (reset) begin
         rdata_q <= 32'h0000_0000;
         irq_q   <= 1'b0;
         wake_q  <= 1'b0;
         busy_q  <= 1'b0;
      end else begin
         rdata_q <= reg_rd ? rdata_d : 32'h0000_0000;
         irq_q   <= |(int_fl & int_en_q);
         wake_q  <= |(wake_fl & wake_en_q);
         busy_q  <= busy_w;
      end
   end

   assign reg_rdata = rdata_q;
   assign irq       = irq_q;
   assign wake_req  = wake_q;
   assign busy      = busy_q;

endmodule // sirq_regs

//--- src/sirq_map.vh
// Purpose: offsets, field positions and reset values of the spi event register bank
// Assumes: 32-bit word registers, byte offsets as printed
// Notes:   included by every design file of the bank
`ifndef SIRQ_MAP_VH
`define SIRQ_MAP_VH

// ---------------------------------------------------------------
// register offsets
// ---------------------------------------------------------------
`define SIRQ_OFS_INT_FL     8'h20
`define SIRQ_OFS_INT_EN     8'h24
`define SIRQ_OFS_WAKE_FL    8'h28
`define SIRQ_OFS_WAKE_EN    8'h2C
`define SIRQ_OFS_STAT       8'h30
`define SIRQ_OFS_MODE       8'h34

// ---------------------------------------------------------------
// implemented bit masks and reset values
// ---------------------------------------------------------------
`define SIRQ_EVT_MASK       32'h0000_FB3F
`define SIRQ_WAKE_MASK      32'h0000_000F
`define SIRQ_RST_INT_EN     32'h0000_0000
`define SIRQ_RST_INT_FL     32'h0000_0000
`define SIRQ_RST_WAKE       32'h0000_0000

// ---------------------------------------------------------------
// event, status and mode bit positions
// ---------------------------------------------------------------
`define SIRQ_B_RX_UND       15
`define SIRQ_B_RX_OVR       14
`define SIRQ_B_TX_UND       13
`define SIRQ_B_TX_OVR       12
`define SIRQ_B_M_DONE       11
`define SIRQ_B_ABORT        9
`define SIRQ_B_FAULT        8
`define SIRQ_B_SSD          5
`define SIRQ_B_SSA          4
`define SIRQ_B_RX_FULL      3
`define SIRQ_B_RX_LEVEL     2
`define SIRQ_B_TX_EMPTY     1
`define SIRQ_B_TX_LEVEL     0
`define SIRQ_B_BUSY         0
`define SIRQ_B_MASTER       0

`endif

//--- src/sirq_w1c_bank.v
// Purpose: bank of sticky event flags, set by hardware, cleared by writing 1
// Assumes: one clock, synchronous active high reset
// Notes:   a set in the clearing cycle wins
`timescale 1ns/10ps
`include "sirq_map.vh"

module sirq_w1c_bank #(
   parameter [31:0] MASK = 32'h0000_0000
) (
   input  wire        sys_clk,
   input  wire        reset,
   input  wire [31:0] set_in,
   input  wire        clr_wr,
   input  wire [31:0] clr_data,
   output wire [31:0] flags
);

   reg [31:0] flag_q;

   // ------------------------------------------------------------
   // per bit sticky flag
   // ------------------------------------------------------------
   genvar i;
   generate
      for (i = 0; i < 32; i = i + 1) begin : g_bit
         if (MASK[i]) begin : g_impl
            // set wins over clear; fixing the source never clears
            always @(posedge sys_clk) begin
               if (reset) begin
                  flag_q[i] <= 1'b0;
               end else if (set_in[i]) begin
                  flag_q[i] <= 1'b1;
               end else if (clr_wr && clr_data[i]) begin
                  flag_q[i] <= 1'b0;
               end
            end
         end else begin : g_rsvd
            always @(posedge sys_clk) begin
               flag_q[i] <= 1'b0;
            end
         end
      end
   endgenerate

   assign flags = flag_q;

endmodule // sirq_w1c_bank

//--- src/sirq_activity.v
// Purpose: activity indicator that follows master transfers and slave select
// Assumes: slave select input is active low and synchronous to sys_clk
// Notes:   master mode uses start and last-character-done pulses
`timescale 1ns/10ps
`include "sirq_map.vh"

module sirq_activity (
   input  wire sys_clk,
   input  wire reset,
   input  wire master_mode,
   input  wire tx_start,
   input  wire last_char_done,
   input  wire ss_n,
   output wire busy,
   output wire ss_fall,
   output wire ss_rise
);

   reg busy_q;
   reg ss_n_q;

   // ------------------------------------------------------------
   // slave select edge detection
   // ------------------------------------------------------------
   always @(posedge sys_clk) begin
      if (reset) begin
         ss_n_q <= 1'b1;
      end else begin
         ss_n_q <= ss_n;
      end
   end

   assign ss_fall = ss_n_q & ~ss_n;
   assign ss_rise = ~ss_n_q & ss_n;

   // ------------------------------------------------------------
   // busy flag
   // ------------------------------------------------------------
   always @(posedge sys_clk) begin
      if (reset) begin
         busy_q <= 1'b0;
      end else if (master_mode) begin
         if (tx_start) begin
            busy_q <= 1'b1;
         end else if (last_char_done) begin
            busy_q <= 1'b0;
         end
      end else begin
         if (ss_fall) begin
            busy_q <= 1'b1;
         end else if (ss_rise) begin
            busy_q <= 1'b0;
         end
      end
   end

   assign busy = busy_q;

endmodule // sirq_activity

//--- testbench/sirq_regs_assertions.sv
// Purpose: port checks of sirq_regs
// Assumes: one clock, sync active high reset
// Notes:   shadows follow enable and mode writes
`timescale 1ns/10ps
module sirq_regs_assertions (
   input wire        sys_clk,
   input wire        reset,
   input wire [7:0]  reg_addr,
   input wire [31:0] reg_wdata,
   input wire        reg_wr,
   input wire        reg_rd,
   input wire [31:0] reg_rdata,
   input wire        ev_tx_empty,
   input wire        tx_start,
   input wire        last_char_done,
   input wire        ss_n,
   input wire        irq,
   input wire        wake_req,
   input wire        busy
);
   reg [31:0] en_q;
   reg        mode_q;
   // shadows of enable word and mode bit
   always @(posedge sys_clk) begin
      if (reset) begin
         en_q <= 32'h0000_0000;
         mode_q <= 1'b0;
      end else if (reg_wr && reg_addr == 8'h24) begin
         en_q <= reg_wdata & 32'h0000_fb3f;
      end else if (reg_wr && reg_addr == 8'h34) begin
         mode_q <= reg_wdata[0];
      end
   end
   default clocking @(posedge sys_clk); endclocking
   default disable iff (reset);
   property p_rd_idle; !$past(reg_rd) |-> reg_rdata == 32'h0000_0000; endproperty
   a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
   property p_en_rd; $past(reg_rd) && $past(reg_addr) == 8'h24 |-> reg_rdata == $past(en_q); endproperty
   a_en_rd: assert property (p_en_rd) else $error("enable readback");
   property p_st_rd; $past(reg_rd) && $past(reg_addr) == 8'h30 |-> reg_rdata == {31'h0000_0000, busy}; endproperty
   a_st_rd: assert property (p_st_rd) else $error("status readback");
   property p_irq_off; $past(en_q) == 32'h0000_0000 |-> !irq; endproperty
   a_irq_off: assert property (p_irq_off) else $error("irq without enable");
   property p_irq_on; ev_tx_empty && en_q[1] && !reg_wr |-> ##2 irq; endproperty
   a_irq_on: assert property (p_irq_on) else $error("irq missing");
   property p_wake_hold; wake_req && !$past(reg_wr) |=> wake_req; endproperty
   a_wake_hold: assert property (p_wake_hold) else $error("wake dropped");
   property p_m_set; tx_start && mode_q |-> ##2 busy; endproperty
   a_m_set: assert property (p_m_set) else $error("busy not set");
   property p_m_clr; last_char_done && mode_q && !tx_start |-> ##2 !busy; endproperty
   a_m_clr: assert property (p_m_clr) else $error("busy not cleared");
   property p_s_set; $fell(ss_n) && !mode_q |-> ##[1:3] busy; endproperty
   a_s_set: assert property (p_s_set) else $error("busy not set on select");
   property p_s_clr; $rose(ss_n) && !mode_q |-> ##[1:3] !busy; endproperty
   a_s_clr: assert property (p_s_clr) else $error("busy not cleared on release");
   c_irq: cover property ($rose(irq));
   c_wake: cover property ($rose(wake_req));
   c_busy: cover property ($rose(busy));
endmodule // sirq_regs_assertions

//--- testbench/sirq_ext_master.sv
// Purpose: external spi master driving slave select
// Assumes: frames requested by the bench
// Notes:   select held low for len+1 cycles
`timescale 1ns/10ps
module sirq_ext_master (
   input  wire       sys_clk,
   input  wire       go,
   input  wire [7:0] len,
   output reg        ss_n
);
   reg [7:0] cnt_q;
   initial ss_n = 1'b1;
   initial cnt_q = 8'h00;
   // select low while the frame count runs
   always @(posedge sys_clk) begin
      if (go) begin
         ss_n <= 1'b0;
         cnt_q <= len;
      end else if (cnt_q != 8'h00) begin
         cnt_q <= cnt_q - 8'h01;
      end else begin
         ss_n <= 1'b1;
      end
   end
endmodule // sirq_ext_master

//--- testbench/tb_top.sv
// Purpose: self-checking bench of sirq_regs
// Assumes: 100 MHz clock, sync reset
// Notes:   random enable words with a fixed all-ones corner
`timescale 1ns/10ps
module tb_top;
   reg         sys_clk, reset, reg_wr, reg_rd, go;
   reg  [7:0]  reg_addr, len;
   reg  [31:0] reg_wdata, v, m;
   reg  [17:0] ev;
   wire [31:0] reg_rdata;
   wire        irq, wake_req, busy, ss_n;
   integer     errors, checks_done, seed, i, b;
   initial begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end
   sirq_regs dut (.sys_clk(sys_clk), .reset(reset), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .ev_rx_und(ev[15]), .ev_rx_ovr(ev[14]), .ev_tx_und(ev[13]), .ev_tx_ovr(ev[12]),
      .ev_m_done(ev[11]), .ev_abort(ev[9]), .ev_fault(ev[8]), .ev_rx_full(ev[3]),
      .ev_rx_level(ev[2]), .ev_tx_empty(ev[1]), .ev_tx_level(ev[0]), .tx_start(ev[16]),
      .last_char_done(ev[17]), .ss_n(ss_n), .irq(irq), .wake_req(wake_req), .busy(busy));
   sirq_ext_master u_peer (.sys_clk(sys_clk), .go(go), .len(len), .ss_n(ss_n));
   function [31:0] en_exp(input [31:0] d);
      en_exp = d & 32'h0000_fb3f;
   endfunction
   task chk(input [31:0] got, input [31:0] exp);
      begin
         checks_done = checks_done + 1;
         if (got !== exp) begin
            errors = errors + 1;
            $display("wrong value at %0t: got %h want %h", $time, got, exp);
         end
      end
   endtask
   task chk1(input got, input exp);
      chk({31'h0000_0000, got}, {31'h0000_0000, exp});
   endtask
   task wr(input [7:0] a, input [31:0] d);
      begin
         @(posedge sys_clk);
         reg_wr <= 1'b1;
         reg_addr <= a;
         reg_wdata <= d;
         @(posedge sys_clk);
         reg_wr <= 1'b0;
      end
   endtask
   task rd(input [7:0] a, input [31:0] exp);
      begin
         @(posedge sys_clk);
         reg_rd <= 1'b1;
         reg_addr <= a;
         @(posedge sys_clk);
         reg_rd <= 1'b0;
         @(negedge sys_clk);
         chk(reg_rdata, exp);
      end
   endtask
   task pulse(input [17:0] p);
      begin
         @(posedge sys_clk);
         ev <= p;
         @(posedge sys_clk);
         ev <= 18'h0_0000;
         @(posedge sys_clk);
         @(negedge sys_clk);
      end
   endtask
   task end_sim;
      begin
         $display("checks %0d mismatches %0d", checks_done, errors);
         if (errors == 0 && checks_done > 0)
            $display("Run complete: PASS");
         else
            $display("Run complete: FAIL");
         $finish;
      end
   endtask
   // watchdog
   initial begin
      #50000;
      errors = errors + 1;
      end_sim;
   end
   // main sequence
   initial begin
      seed = 32'h1eaa_2fb8;
      errors = 0;
      checks_done = 0;
      reset = 1'b1;
      {reg_wr, reg_rd, go} = 3'h0;
      {reg_addr, len, reg_wdata, ev} = 0;
      repeat (3) @(posedge sys_clk);
      reset <= 1'b0;
      rd(8'h24, 32'h0000_0000);
      rd(8'h28, 32'h0000_0000);
      rd(8'h2c, 32'h0000_0000);
      rd(8'h30, 32'h0000_0000);
      wr(8'h3c, 32'hffff_ffff);
      rd(8'h3c, 32'h0000_0000);
      for (i = 0; i < 8; i = i + 1) begin
         v = (i == 0) ? 32'hffff_ffff : $random(seed);
         wr(8'h24, en_exp(v));
         rd(8'h24, en_exp(v));
      end
      $display("test reset and enables done");
      // every event source except the slave select pair (bits 5, 4) gated by its own enable bit
      for (b = 0; b < 16; b = b + 1) if (16'hfb0f >> b & 1) begin
         m = 32'h0000_0001 << b;
         wr(8'h34, {31'h0000_0000, b == 11});
         wr(8'h24, m);
         pulse(m[17:0]);
         chk1(irq, 1'b1);
         chk1(wake_req, 1'b0);
         wr(8'h24, en_exp(~m));
         rd(8'h20, m);
         chk1(irq, 1'b0);
         wr(8'h20, m);
         rd(8'h20, 32'h0000_0000);
      end
      $display("test event gating done");
      wr(8'h24, 32'h0000_0000);
      wr(8'h28, 32'h0000_000f);
      for (b = 0; b < 4; b = b + 1) begin
         m = 32'h0000_0001 << b;
         wr(8'h2c, m);
         rd(8'h2c, m);
         pulse(m[17:0]);
         chk1(wake_req, 1'b1);
         rd(8'h28, m);
         wr(8'h28, 32'h0000_0000);
         rd(8'h28, m);
         wr(8'h28, m);
         rd(8'h28, 32'h0000_0000);
         wr(8'h20, m);
      end
      $display("test wake flags done");
      wr(8'h34, 32'h0000_0001);
      pulse(18'h1_0000);
      rd(8'h30, 32'h0000_0001);
      chk1(busy, 1'b1);
      pulse(18'h2_0000);
      rd(8'h30, 32'h0000_0000);
      chk1(busy, 1'b0);
      wr(8'h34, 32'h0000_0000);
      wr(8'h24, 32'h0000_0030);
      @(posedge sys_clk);
      go <= 1'b1;
      len <= 8'h14;
      @(posedge sys_clk);
      go <= 1'b0;
      repeat (4) @(posedge sys_clk);
      rd(8'h30, 32'h0000_0001);
      chk1(busy, 1'b1);
      chk1(irq, 1'b1);
      repeat (30) @(posedge sys_clk);
      rd(8'h30, 32'h0000_0000);
      chk1(busy, 1'b0);
      rd(8'h20, 32'h0000_0030);
      $display("test activity done");
      end_sim;
   end
endmodule // tb_top
bind sirq_regs sirq_regs_assertions u_chk (.sys_clk(sys_clk), .reset(reset),
   .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
   .reg_rdata(reg_rdata), .ev_tx_empty(ev_tx_empty), .tx_start(tx_start),
   .last_char_done(last_char_done), .ss_n(ss_n), .irq(irq), .wake_req(wake_req),
   .busy(busy));
